// ==== rtl/bldq_pkg.sv ====
// Notes on behaviour
// - Bulk descriptors are served round-robin in their list insertion order.
// - After serving a descriptor, bulk current pointer bits 31:4 advance to the next.
// - Each new frame resumes bulk processing where the previous frame stopped.
// - At bulk list end, test list-filled flag; when clear, change nothing.
// - At bulk list end with flag set, load head into current and clear flag.
// - With bulk processing enabled, reads return the live bulk current pointer.
// - Bulk current pointer resets to zero, meaning end of bulk list.
// - On descriptor completion, write done head into its next-descriptor link field.
// - After linking, done head register takes the completed descriptor's address.
// - Done head is periodically copied into the shared communication area.
// - Each copy of done head to the shared area clears the register to zero.
// - Frame interval register holds a 14-bit bit-time count between start-of-frames.
// - Frame interval register holds a 15-bit full-speed largest packet size.
// - Software may trim the interval at any start-of-frame; later frames use it.
// - Interval count sits in bits 13:0, reset to 11,999 bit times.
// - Largest-packet field bits 30:16 loads the packet counter every frame start.
package bldq_pkg;
	// register offsets from the base address
	localparam logic [7:0]  OFS_BULK_CUR   = 8'h2c;
	localparam logic [7:0]  OFS_DONE_HEAD  = 8'h30;
	localparam logic [7:0]  OFS_FRAME_INTV = 8'h34;

	// pointer field layout
	localparam int unsigned PTR_LSB        = 4;
	localparam int unsigned PTR_W          = 28;
	localparam logic [27:0] PTR_RESET      = 28'h0000000;

	// frame interval register layout
	localparam int unsigned FI_LSB         = 0;
	localparam int unsigned FI_W           = 14;
	localparam int unsigned LPS_LSB        = 16;
	localparam int unsigned LPS_W          = 15;
	localparam int unsigned FIT_BIT        = 31;
	localparam logic [31:0] FMI_WR_MASK    = 32'hffff3fff;
	localparam logic [13:0] FI_RESET       = 14'h2edf;
	localparam logic [14:0] LPS_RESET      = 15'h0000;
	localparam logic        FIT_RESET      = 1'b0;

	// memory write offsets of the engine
	localparam logic [31:0] LINK_FIELD_OFS = 32'h00000008;
	localparam logic [31:0] SCA_DONE_OFS   = 32'h00000084;

	// done queue writer states
	typedef enum logic [1:0] {
		WB_IDLE,
		WB_LINK,
		WB_SCA
	} bldq_wb_t;
endpackage

// ==== rtl/bldq_frame_timer.sv ====
// frame timer: bit-time down counter and largest-packet counter
module bldq_frame_timer (
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic        bit_tick,
	input  wire logic [13:0] frame_interval_count,
	input  wire logic [14:0] fs_largest_packet_field,
	output logic             sof_pulse,
	output logic [13:0]      frame_remaining,
	output logic [14:0]      largest_packet_count
);
	typedef struct packed {
		logic [13:0] remain;
		logic [14:0] lpc;
	} bldq_ft_state_t;

	bldq_ft_state_t s_q;
	bldq_ft_state_t s_d;

	// frame boundary when the counter expires on a bit tick
	assign sof_pulse            = bit_tick && (s_q.remain == 14'h0000);
	assign frame_remaining      = s_q.remain;
	assign largest_packet_count = s_q.lpc;

	// next-state of both counters
	always_comb begin
		s_d = s_q;
		if (bit_tick) begin
			if (s_q.remain == 14'h0000) begin
				s_d.remain = frame_interval_count;     // new interval for the next frame
				s_d.lpc    = fs_largest_packet_field;  // reload at frame start
			end else begin
				s_d.remain = s_q.remain - 14'h0001;
				if (s_q.lpc != 15'h0000) begin
					s_d.lpc = s_q.lpc - 15'h0001;
				end
			end
		end
	end

	// state register
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			s_q.remain <= bldq_pkg::FI_RESET;
			s_q.lpc    <= bldq_pkg::LPS_RESET;
		end else begin
			s_q <= s_d;
		end
	end
endmodule // bldq_frame_timer

// ==== rtl/bldq_regs.sv ====
// bulk list pointer, done queue head and frame interval registers
module bldq_regs #(
	parameter int unsigned ADDR_W = 8
) (
	input  wire logic              sys_clk,
	input  wire logic              rst_n,
	// register access at base address plus offset
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic [31:0]       reg_wdata,
	output logic [31:0]            reg_rdata,
	output logic                   reg_rvalid,
	// loose control and status bits
	input  wire logic              bulk_list_enable,
	input  wire logic              list_filled_flag,
	output logic                   list_filled_clear,
	input  wire logic [31:0]       bulk_list_head_pointer,
	// list engine side
	input  wire logic              bulk_ed_served,
	input  wire logic [31:0]       bulk_next_ed,
	input  wire logic              bulk_list_end,
	output logic [31:0]            bulk_list_current_pointer,
	// frame timing
	input  wire logic              bit_tick,
	output logic                   sof_pulse,
	output logic [14:0]            largest_packet_count,
	// completed descriptors
	input  wire logic              td_done_valid,
	output logic                   td_done_ready,
	input  wire logic [31:0]       td_done_addr,
	// memory writes
	input  wire logic [31:0]       shared_comm_area_base,
	output logic                   mem_wr_valid,
	input  wire logic              mem_wr_ready,
	output logic [31:0]            mem_wr_addr,
	output logic [31:0]            mem_wr_data
);
	typedef struct packed {
		logic [27:0]        cur;       // bulk current address field
		logic [27:0]        done;      // done queue address field
		logic [31:0]        fmi;       // frame interval register image
		logic [27:0]        td;        // descriptor being linked
		bldq_pkg::bldq_wb_t wb;
		logic               sca_due;   // copy to shared area requested
		logic               flag_clr;
		logic [31:0]        rdata;
		logic               rvalid;
		logic               wvalid;
		logic [31:0]        waddr;
		logic [31:0]        wdata;
	} bldq_regs_state_t;

	bldq_regs_state_t s_q;
	bldq_regs_state_t s_d;

	logic [13:0] fi_val;
	logic [14:0] lps_val;
	logic        sof_int;
	logic [31:0] rd_mux;
	logic        hit_cur;
	logic        hit_done;
	logic        hit_fmi;

	// compares the whole address against a register offset
	function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
		addr_hit = (32'(a) == {24'h000000, ofs});  // upper address bits must be zero
	endfunction

	// expands a 28-bit pointer field into a full word
	function automatic logic [31:0] ptr_word(input logic [27:0] f);
		ptr_word = {f, 4'h0};  // reserved low bits read zero
	endfunction

	assign hit_cur  = addr_hit(reg_addr, bldq_pkg::OFS_BULK_CUR);
	assign hit_done = addr_hit(reg_addr, bldq_pkg::OFS_DONE_HEAD);
	assign hit_fmi  = addr_hit(reg_addr, bldq_pkg::OFS_FRAME_INTV);

	// interval and packet size fields for the timer
	assign fi_val  = s_q.fmi[bldq_pkg::FI_LSB +: bldq_pkg::FI_W];
	assign lps_val = s_q.fmi[bldq_pkg::LPS_LSB +: bldq_pkg::LPS_W];

	bldq_frame_timer u_timer (
		.sys_clk                 (sys_clk),
		.rst_n                   (rst_n),
		.bit_tick                (bit_tick),
		.frame_interval_count    (fi_val),
		.fs_largest_packet_field (lps_val),
		.sof_pulse               (sof_int),
		.frame_remaining         (),
		.largest_packet_count    (largest_packet_count)
	);

	// read data selection, reads show live hardware state
	always_comb begin
		rd_mux = 32'h00000000;
		if (hit_cur) begin
			rd_mux = ptr_word(s_q.cur);  // engine's live value
		end else if (hit_done) begin
			rd_mux = ptr_word(s_q.done);
		end else if (hit_fmi) begin
			rd_mux = s_q.fmi;
		end
	end

	// outputs
	assign sof_pulse                 = sof_int;
	assign reg_rdata                 = s_q.rdata;
	assign reg_rvalid                = s_q.rvalid;
	assign list_filled_clear         = s_q.flag_clr;
	assign bulk_list_current_pointer = ptr_word(s_q.cur);
	assign td_done_ready             = (s_q.wb == bldq_pkg::WB_IDLE) && !s_q.sca_due;
	assign mem_wr_valid              = s_q.wvalid;
	assign mem_wr_addr               = s_q.waddr;
	assign mem_wr_data               = s_q.wdata;

	// next-state logic
	always_comb begin
		s_d          = s_q;
		s_d.rvalid   = reg_rd;
		s_d.flag_clr = 1'b0;
		if (reg_rd) begin
			s_d.rdata = rd_mux;
		end

		// software writes; pointer low bits dropped
		if (reg_wr && hit_cur && !bulk_list_enable) begin
			s_d.cur = reg_wdata[31:bldq_pkg::PTR_LSB];  // only with list stopped
		end
		if (reg_wr && hit_done) begin
			s_d.done = reg_wdata[31:bldq_pkg::PTR_LSB];
		end
		if (reg_wr && hit_fmi) begin
			s_d.fmi = reg_wdata & bldq_pkg::FMI_WR_MASK;  // trim for later frames
		end

		// bulk list walk; pointer untouched at frame start
		if (bulk_list_end) begin
			if (list_filled_flag) begin
				s_d.cur      = bulk_list_head_pointer[31:bldq_pkg::PTR_LSB];
				s_d.flag_clr = 1'b1;
			end  // flag clear: nothing changes
		end else if (bulk_ed_served) begin
			s_d.cur = bulk_next_ed[31:bldq_pkg::PTR_LSB];  // insertion order round-robin
		end

		// periodic copy of done head, requested each frame
		if (sof_int) begin
			s_d.sca_due = 1'b1;
		end

		// done queue writer
		unique case (s_q.wb)
			bldq_pkg::WB_IDLE: begin
				if (s_q.sca_due) begin
					s_d.sca_due = sof_int;
					if (s_q.done != bldq_pkg::PTR_RESET) begin
						s_d.wb     = bldq_pkg::WB_SCA;
						s_d.wvalid = 1'b1;
						s_d.waddr  = shared_comm_area_base + bldq_pkg::SCA_DONE_OFS;
						s_d.wdata  = ptr_word(s_d.done);
					end
				end else if (td_done_valid) begin
					s_d.wb     = bldq_pkg::WB_LINK;
					s_d.td     = td_done_addr[31:bldq_pkg::PTR_LSB];
					s_d.wvalid = 1'b1;
					s_d.waddr  = {td_done_addr[31:4], 4'h0} + bldq_pkg::LINK_FIELD_OFS;
					s_d.wdata  = ptr_word(s_d.done);  // old head into link field
				end
			end
			bldq_pkg::WB_LINK: begin
				if (mem_wr_ready) begin
					s_d.wb     = bldq_pkg::WB_IDLE;
					s_d.wvalid = 1'b0;
					s_d.done   = s_q.td;  // queue grows at its head
				end
			end
			bldq_pkg::WB_SCA: begin
				if (mem_wr_ready) begin
					s_d.wb     = bldq_pkg::WB_IDLE;
					s_d.wvalid = 1'b0;
					s_d.done   = bldq_pkg::PTR_RESET;  // cleared on each copy
				end
			end
			default: begin
				s_d.wb     = bldq_pkg::WB_IDLE;
				s_d.wvalid = 1'b0;
			end
		endcase
	end

	// state register
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			s_q.cur      <= bldq_pkg::PTR_RESET;  // zero means end of list
			s_q.done     <= bldq_pkg::PTR_RESET;
			s_q.fmi      <= {bldq_pkg::FIT_RESET, bldq_pkg::LPS_RESET, 2'b00,
			                 bldq_pkg::FI_RESET};  // nominal interval
			s_q.td       <= bldq_pkg::PTR_RESET;
			s_q.wb       <= bldq_pkg::WB_IDLE;
			s_q.sca_due  <= 1'b0;
			s_q.flag_clr <= 1'b0;
			s_q.rdata    <= 32'h00000000;
			s_q.rvalid   <= 1'b0;
			s_q.wvalid   <= 1'b0;
			s_q.waddr    <= 32'h00000000;
			s_q.wdata    <= 32'h00000000;
		end else begin
			s_q <= s_d;
		end
	end
endmodule // bldq_regs

// ==== tb/bldq_regs_properties.sv ====
module bldq_regs_properties #(
	parameter int unsigned ADDR_W = 8
) (
	input wire logic              sys_clk,
	input wire logic              rst_n,
	input wire logic              reg_wr,
	input wire logic              reg_rd,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [31:0]       reg_rdata,
	input wire logic              reg_rvalid,
	input wire logic              list_filled_flag,
	input wire logic              list_filled_clear,
	input wire logic [31:0]       bulk_list_head_pointer,
	input wire logic              bulk_ed_served,
	input wire logic [31:0]       bulk_next_ed,
	input wire logic              bulk_list_end,
	input wire logic [31:0]       bulk_list_current_pointer,
	input wire logic              td_done_valid,
	input wire logic              td_done_ready,
	input wire logic [31:0]       td_done_addr,
	input wire logic              mem_wr_valid,
	input wire logic              mem_wr_ready,
	input wire logic [31:0]       mem_wr_addr,
	input wire logic [31:0]       mem_wr_data
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// register access and bulk pointer behaviour
	read_answered_a: assert property (reg_rd |=> reg_rvalid)
		else $error("read not answered");
	live_pointer_a: assert property (reg_rd && reg_addr == bldq_pkg::OFS_BULK_CUR
		|=> reg_rdata == $past(bulk_list_current_pointer)) else $error("stale pointer read");
	pointer_advance_a: assert property (bulk_ed_served && !bulk_list_end
		|=> bulk_list_current_pointer == ($past(bulk_next_ed) & 32'hfffffff0))
		else $error("pointer did not advance");
	list_refill_a: assert property (bulk_list_end && list_filled_flag
		|=> list_filled_clear && bulk_list_current_pointer ==
		($past(bulk_list_head_pointer) & 32'hfffffff0)) else $error("refill wrong");
	end_no_flag_a: assert property (bulk_list_end && !list_filled_flag && !reg_wr
		|=> $stable(bulk_list_current_pointer) && !list_filled_clear) else $error("end acted");
	low_bits_zero_a: assert property (bulk_list_current_pointer[3:0] == 4'h0)
		else $error("pointer low bits set");
	// completion writes
	link_write_a: assert property (td_done_valid && td_done_ready |=> mem_wr_valid
		&& mem_wr_addr == ($past(td_done_addr) & 32'hfffffff0) + bldq_pkg::LINK_FIELD_OFS)
		else $error("link write wrong");
	write_held_a: assert property (mem_wr_valid && !mem_wr_ready |=> mem_wr_valid
		&& $stable(mem_wr_addr) && $stable(mem_wr_data)) else $error("write not held");
	one_outstanding_a: assert property (mem_wr_valid |-> !td_done_ready)
		else $error("completion taken while busy");
	cover property (bulk_list_end && list_filled_flag);
	cover property (td_done_valid && td_done_ready);
	cover property (mem_wr_valid && mem_wr_ready);
endmodule // bldq_regs_properties

bind bldq_regs bldq_regs_properties #(.ADDR_W(ADDR_W)) chk_u (.sys_clk, .rst_n, .reg_wr,
	.reg_rd, .reg_addr, .reg_rdata, .reg_rvalid, .list_filled_flag, .list_filled_clear,
	.bulk_list_head_pointer, .bulk_ed_served, .bulk_next_ed, .bulk_list_end,
	.bulk_list_current_pointer, .td_done_valid, .td_done_ready, .td_done_addr,
	.mem_wr_valid, .mem_wr_ready, .mem_wr_addr, .mem_wr_data);

// ==== tb/bldq_mem_model.sv ====
module bldq_mem_model (
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic [3:0]  delay,
	input  wire logic        mem_wr_valid,
	output logic             mem_wr_ready,
	input  wire logic [31:0] mem_wr_addr,
	input  wire logic [31:0] mem_wr_data,
	output logic [31:0]      last_addr,
	output logic [31:0]      last_data,
	output logic [7:0]       wr_count
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] wait_q;
	// memory side: takes one write after a set number of wait cycles
	always @(posedge sys_clk) begin
		if (!rst_n) begin
			mem_wr_ready <= 1'b0;
			wait_q <= 4'h0;
			wr_count <= 8'h00;
		end else if (mem_wr_valid && mem_wr_ready) begin
			mem_wr_ready <= 1'b0;
			wait_q <= 4'h0;
			last_addr <= mem_wr_addr;
			last_data <= mem_wr_data;
			wr_count <= wr_count + 8'h01;
		end else if (mem_wr_valid && wait_q == delay) begin
			mem_wr_ready <= 1'b1;
		end else if (mem_wr_valid) begin
			wait_q <= wait_q + 4'h1;
		end
	end
endmodule // bldq_mem_model

// ==== tb/bulk_list_done_queue_regs_bench.sv ====
module bulk_list_done_queue_regs_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        sys_clk, rst_n, reg_wr, reg_rd, reg_rvalid, bulk_list_enable, list_filled_flag;
	logic        list_filled_clear, bulk_ed_served, bulk_list_end, bit_tick, sof_pulse;
	logic        td_done_valid, td_done_ready, mem_wr_valid, mem_wr_ready;
	logic [3:0]  delay;
	logic [7:0]  reg_addr, wr_count;
	logic [14:0] largest_packet_count;
	logic [31:0] reg_wdata, reg_rdata, bulk_list_head_pointer, bulk_next_ed;
	logic [31:0] bulk_list_current_pointer, td_done_addr, shared_comm_area_base;
	logic [31:0] mem_wr_addr, mem_wr_data, last_addr, last_data;
	int          err_count = 0, comparisons = 0, cyc = 0, n, t0;

	bldq_regs dut_u (.sys_clk, .rst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
		.reg_rvalid, .bulk_list_enable, .list_filled_flag, .list_filled_clear,
		.bulk_list_head_pointer, .bulk_ed_served, .bulk_next_ed, .bulk_list_end,
		.bulk_list_current_pointer, .bit_tick, .sof_pulse, .largest_packet_count,
		.td_done_valid, .td_done_ready, .td_done_addr, .shared_comm_area_base,
		.mem_wr_valid, .mem_wr_ready, .mem_wr_addr, .mem_wr_data);
	bldq_mem_model mem_u (.sys_clk, .rst_n, .delay, .mem_wr_valid, .mem_wr_ready,
		.mem_wr_addr, .mem_wr_data, .last_addr, .last_data, .wr_count);

	// clock and hang guard
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			results();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %0t got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge sys_clk);
		reg_wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		reg_rd = 1'b1;
		reg_addr = a;
		@(negedge sys_clk);
		reg_rd = 1'b0;
		check({31'h0, reg_rvalid}, 32'h1);
		check(reg_rdata, exp);
	endtask
	// one engine event: list end or descriptor served
	task automatic pulse(input logic e, input logic f, input logic [31:0] nxt);
		bulk_list_end = e;
		bulk_ed_served = !e;
		list_filled_flag = f;
		bulk_next_ed = nxt;
		@(negedge sys_clk);
		bulk_list_end = 1'b0;
		bulk_ed_served = 1'b0;
	endtask
	task automatic td(input logic [31:0] a);
		n = int'(wr_count);
		td_done_valid = 1'b1;
		td_done_addr = a;
		while (td_done_ready !== 1'b1) @(negedge sys_clk);
		@(negedge sys_clk);
		td_done_valid = 1'b0;
		while (wr_count == 8'(n)) @(negedge sys_clk);
	endtask
	task automatic results();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// main sequence
	initial begin
		{rst_n, reg_wr, reg_rd, bulk_list_enable, list_filled_flag} = '0;
		{bulk_ed_served, bulk_list_end, bit_tick, td_done_valid} = '0;
		{reg_addr, reg_wdata, bulk_next_ed, td_done_addr} = '0;
		bulk_list_head_pointer = 32'h00000a00;
		shared_comm_area_base = 32'h00004000;
		delay = 4'h3;
		repeat (10) @(negedge sys_clk);
		rst_n = 1'b1;
		bit_tick = 1'b1;
		rd(8'h2c, 32'h0);
		rd(8'h30, 32'h0);
		rd(8'h34, 32'h00002edf);
		rd(8'h40, 32'h0);
		wr(8'h2c, 32'h12345670);
		rd(8'h2c, 32'h12345670);
		bulk_list_enable = 1'b1;
		wr(8'h2c, 32'h0bad0000);
		rd(8'h2c, 32'h12345670);
		$display("test registers done");
		pulse(1'b0, 1'b0, 32'h00000200);
		rd(8'h2c, 32'h00000200);
		pulse(1'b0, 1'b0, 32'h0000030f);
		check(bulk_list_current_pointer, 32'h00000300);
		pulse(1'b1, 1'b0, 32'h0);
		check({31'h0, list_filled_clear}, 32'h0);
		check(bulk_list_current_pointer, 32'h00000300);
		pulse(1'b1, 1'b1, 32'h0);
		check({31'h0, list_filled_clear}, 32'h1);
		check(bulk_list_current_pointer, 32'h00000a00);
		$display("test bulk done");
		td(32'h00001000);
		check(last_addr, 32'h00001008);
		check(last_data, 32'h0);
		rd(8'h30, 32'h00001000);
		delay = 4'h0;
		td(32'h00002000);
		check(last_data, 32'h00001000);
		wr(8'h34, 32'h81000009);
		$display("test done queue done");
		n = int'(wr_count);
		while (sof_pulse !== 1'b1) @(negedge sys_clk);
		t0 = cyc;
		do @(negedge sys_clk); while (sof_pulse !== 1'b1);
		check(32'(cyc - t0), 32'd10);
		@(negedge sys_clk);
		check({17'h0, largest_packet_count}, 32'h00000100);
		check({24'h0, wr_count}, 32'(n + 1));
		check(last_addr, 32'h00004084);
		check(last_data, 32'h00002000);
		rd(8'h30, 32'h0);
		rd(8'h34, 32'h81000009);
		check(bulk_list_current_pointer, 32'h00000a00);
		$display("test frame done");
		results();
	end
endmodule // bulk_list_done_queue_regs_bench
